//--- hw/pmic_interrupt_mask_bank.sv
// pmic_interrupt_mask_bank: mask registers, latched event flags and raw
// status views of the power-management device's system and converter events.
// assumes an upstream serial-interface engine issuing byte reads/writes,
// and event sources already synchronous to clk.
`timescale 1ns/1ps
module pmic_interrupt_mask_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access from the serial interface engine
  input wire pmic_pkg::pmic_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // one-time-programmable default for the reset-event mask
  input wire logic otp_reset_event_suppress,
  // event sources
  input wire pmic_pkg::pmic_src_t src,
  // mask and flag views for the device
  output logic [7:0] system_irq_mask,
  output logic [7:0] reset_event_irq_mask,
  output logic [7:0] converter_irq_mask,
  output logic [pmic_pkg::PMIC_FLAG_WIDTH-1:0] event_flags
);
  import pmic_pkg::*;

  typedef struct packed {
    logic [7:0] sys_mask;
    logic [7:0] rst_mask;
    logic [7:0] conv_mask;
    logic otp_loaded;
    pmic_src_t prev;
    logic [7:0] rdata;
    logic rvalid;
  } pmic_bank_state_t;

  pmic_bank_state_t state;
  pmic_bank_state_t next_state;
  logic [PMIC_FLAG_WIDTH-1:0] flag_set;
  logic [PMIC_FLAG_WIDTH-1:0] flag_clear;
  logic [PMIC_FLAG_WIDTH-1:0] flags;
  logic [7:0] top_state;
  logic [7:0] conv_state;
  logic power_good_irq_suppress;
  logic sync_clk_irq_suppress;
  logic thermal_warning_irq_suppress;
  logic current_measure_done_irq_suppress;
  logic reset_event_irq_suppress;
  logic conv1_output_invalid_suppress;
  logic conv1_output_valid_suppress;
  logic conv1_current_limit_suppress;
  logic conv0_output_invalid_suppress;
  logic conv0_output_valid_suppress;
  logic conv0_current_limit_suppress;

  // ------------------------------------------------------------
  // mask fields
  // ------------------------------------------------------------
  assign power_good_irq_suppress = state.sys_mask[PMIC_POWER_GOOD_BIT];
  assign sync_clk_irq_suppress = state.sys_mask[PMIC_SYNC_CLK_BIT];
  assign thermal_warning_irq_suppress = state.sys_mask[PMIC_THERMAL_BIT];
  assign current_measure_done_irq_suppress = state.sys_mask[PMIC_MEASURE_BIT];
  assign reset_event_irq_suppress = state.rst_mask[PMIC_RESET_EVENT_BIT];
  assign conv1_output_invalid_suppress = state.conv_mask[PMIC_CONV1_INVALID_BIT];
  assign conv1_output_valid_suppress = state.conv_mask[PMIC_CONV1_VALID_BIT];
  assign conv1_current_limit_suppress = state.conv_mask[PMIC_CONV1_ILIM_BIT];
  assign conv0_output_invalid_suppress = state.conv_mask[PMIC_CONV0_INVALID_BIT];
  assign conv0_output_valid_suppress = state.conv_mask[PMIC_CONV0_VALID_BIT];
  assign conv0_current_limit_suppress = state.conv_mask[PMIC_CONV0_ILIM_BIT];

  // ------------------------------------------------------------
  // raw status: live inputs, never touched by masks
  // ------------------------------------------------------------
  always_comb begin
    top_state = 8'h00;
    top_state[PMIC_POWER_GOOD_BIT] = src.power_good_pin_state;
    top_state[PMIC_SYNC_CLK_BIT] = src.sync_clk_invalid_state;
    top_state[PMIC_THERMAL_BIT] = src.thermal_warning_state;
    conv_state = 8'h00;
    conv_state[PMIC_CONV1_PG_BIT] = src.conv1_output_validity_state;
    conv_state[PMIC_CONV1_ILIM_BIT] = src.conv1_current_limit_state;
    conv_state[PMIC_CONV0_PG_BIT] = src.conv0_output_validity_state;
    conv_state[PMIC_CONV0_ILIM_BIT] = src.conv0_current_limit_state;
  end

  // ------------------------------------------------------------
  // event gating: a suppressed event never reaches its flag
  // ------------------------------------------------------------
  always_comb begin
    flag_set = '0;
    // power-good and sync-clock raise an event on any change, thermal and current limit only on a rise; validity state 1 = invalid
    flag_set[PMIC_POWER_GOOD_BIT] = ~power_good_irq_suppress
      & (src.power_good_pin_state ^ state.prev.power_good_pin_state);
    flag_set[PMIC_SYNC_CLK_BIT] = ~sync_clk_irq_suppress
      & (src.sync_clk_invalid_state ^ state.prev.sync_clk_invalid_state);
    flag_set[PMIC_THERMAL_BIT] = ~thermal_warning_irq_suppress
      & src.thermal_warning_state & ~state.prev.thermal_warning_state;
    flag_set[PMIC_MEASURE_BIT] = ~current_measure_done_irq_suppress
      & src.current_measure_done;
    flag_set[8 + PMIC_RESET_EVENT_BIT] = ~reset_event_irq_suppress
      & src.register_reset_done;
    flag_set[16 + PMIC_CONV1_PG_BIT] =
      (~conv1_output_invalid_suppress & src.conv1_output_validity_state
        & ~state.prev.conv1_output_validity_state)
      | (~conv1_output_valid_suppress & ~src.conv1_output_validity_state
        & state.prev.conv1_output_validity_state);
    flag_set[16 + PMIC_CONV1_ILIM_BIT] = ~conv1_current_limit_suppress
      & src.conv1_current_limit_state & ~state.prev.conv1_current_limit_state;
    flag_set[16 + PMIC_CONV0_PG_BIT] =
      (~conv0_output_invalid_suppress & src.conv0_output_validity_state
        & ~state.prev.conv0_output_validity_state)
      | (~conv0_output_valid_suppress & ~src.conv0_output_validity_state
        & state.prev.conv0_output_validity_state);
    flag_set[16 + PMIC_CONV0_ILIM_BIT] = ~conv0_current_limit_suppress
      & src.conv0_current_limit_state & ~state.prev.conv0_current_limit_state;
  end

  // ------------------------------------------------------------
  // write-one-to-clear strobes
  // ------------------------------------------------------------
  always_comb begin
    flag_clear = '0;
    if (reg_req.wr) begin
      case (reg_req.addr)
        PMIC_SYS_FLAG_ADDR: flag_clear[7:0] = reg_req.wdata;
        PMIC_RST_FLAG_ADDR: flag_clear[15:8] = reg_req.wdata;
        PMIC_CONV_FLAG_ADDR: flag_clear[23:16] = reg_req.wdata;
        default: flag_clear = '0;
      endcase
    end
  end

  pmic_flag_cells #(
    .WIDTH(PMIC_FLAG_WIDTH)
  ) u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .set(flag_set),
    .clear(flag_clear),
    .flags(flags)
  );

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.prev = src;
    next_state.rvalid = reg_req.rd;
    if (reg_req.wr) begin
      case (reg_req.addr)
        PMIC_SYS_MASK_ADDR: next_state.sys_mask = reg_req.wdata;
        PMIC_RST_MASK_ADDR: next_state.rst_mask = reg_req.wdata;
        PMIC_CONV_MASK_ADDR: next_state.conv_mask = reg_req.wdata
          & PMIC_CONV_MASK_WRITABLE;
        default: next_state.sys_mask = state.sys_mask;
      endcase
    end
    // the strap cannot be taken under async reset, so it is loaded at the
    // first edge after release; a host write only lasts until next reset
    if (!state.otp_loaded) begin
      next_state.otp_loaded = 1'b1;
      next_state.rst_mask[PMIC_RESET_EVENT_BIT] = otp_reset_event_suppress;
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        PMIC_SYS_FLAG_ADDR: next_state.rdata = flags[7:0];
        PMIC_RST_FLAG_ADDR: next_state.rdata = flags[15:8];
        PMIC_CONV_FLAG_ADDR: next_state.rdata = flags[23:16];
        PMIC_TOP_STATE_ADDR: next_state.rdata = top_state;
        PMIC_CONV_STATE_ADDR: next_state.rdata = conv_state;
        PMIC_SYS_MASK_ADDR: next_state.rdata = state.sys_mask;
        PMIC_RST_MASK_ADDR: next_state.rdata = state.rst_mask;
        PMIC_CONV_MASK_ADDR: next_state.rdata = state.conv_mask;
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state.sys_mask <= PMIC_SYS_MASK_RESET;
      state.rst_mask <= PMIC_RST_MASK_RESET;
      state.conv_mask <= PMIC_CONV_MASK_RESET;
      state.otp_loaded <= 1'b0;
      state.prev <= '0;
      state.rdata <= 8'h00;
      state.rvalid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign system_irq_mask = state.sys_mask;
  assign reset_event_irq_mask = state.rst_mask;
  assign converter_irq_mask = state.conv_mask;
  assign event_flags = flags;

endmodule

//--- hw/pmic_pkg.sv
// pmic_pkg: register map, field positions, reset values and carriers
// for the interrupt mask bank; shared by the bank and its flag cells.
package pmic_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PMIC_SYS_FLAG_ADDR = 8'h1a;
  localparam logic [7:0] PMIC_RST_FLAG_ADDR = 8'h1b;
  localparam logic [7:0] PMIC_CONV_FLAG_ADDR = 8'h1c;
  localparam logic [7:0] PMIC_TOP_STATE_ADDR = 8'h1d;
  localparam logic [7:0] PMIC_CONV_STATE_ADDR = 8'h1e;
  localparam logic [7:0] PMIC_SYS_MASK_ADDR = 8'h20;
  localparam logic [7:0] PMIC_RST_MASK_ADDR = 8'h21;
  localparam logic [7:0] PMIC_CONV_MASK_ADDR = 8'h22;

  // ------------------------------------------------------------
  // field positions (system registers)
  // ------------------------------------------------------------
  localparam int PMIC_POWER_GOOD_BIT = 7;
  localparam int PMIC_SYNC_CLK_BIT = 4;
  localparam int PMIC_THERMAL_BIT = 2;
  localparam int PMIC_MEASURE_BIT = 0;
  localparam int PMIC_RESET_EVENT_BIT = 0;

  // ------------------------------------------------------------
  // field positions (converter registers)
  // ------------------------------------------------------------
  localparam int PMIC_CONV1_INVALID_BIT = 7;
  localparam int PMIC_CONV1_VALID_BIT = 6;
  localparam int PMIC_CONV1_PG_BIT = 6;
  localparam int PMIC_CONV1_ILIM_BIT = 4;
  localparam int PMIC_CONV0_INVALID_BIT = 3;
  localparam int PMIC_CONV0_VALID_BIT = 2;
  localparam int PMIC_CONV0_PG_BIT = 2;
  localparam int PMIC_CONV0_ILIM_BIT = 0;

  // ------------------------------------------------------------
  // reset values and writable bits
  // ------------------------------------------------------------
  localparam logic [7:0] PMIC_SYS_MASK_RESET = 8'h91;
  localparam logic [7:0] PMIC_RST_MASK_RESET = 8'h01;
  localparam logic [7:0] PMIC_CONV_MASK_RESET = 8'hdd;
  localparam logic [7:0] PMIC_CONV_MASK_WRITABLE = 8'hdd;
  localparam int PMIC_FLAG_WIDTH = 24;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmic_reg_req_t;

  typedef struct packed {
    logic power_good_pin_state;
    logic sync_clk_invalid_state;
    logic thermal_warning_state;
    logic current_measure_done;
    logic register_reset_done;
    logic conv0_output_validity_state;
    logic conv0_current_limit_state;
    logic conv1_output_validity_state;
    logic conv1_current_limit_state;
  } pmic_src_t;

endpackage

//--- hw/pmic_flag_cells.sv
// pmic_flag_cells: a row of latched event flags, write-one-to-clear.
// assumes set and clear are single-cycle pulses in the clk domain.
`timescale 1ns/1ps
module pmic_flag_cells #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and clears
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clear,
  // flags
  output logic [WIDTH-1:0] flags
);
  import pmic_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } pmic_cell_state_t;

  pmic_cell_state_t state;
  pmic_cell_state_t next_state;

  // ------------------------------------------------------------
  // per-bit latch: a set in the clearing cycle is kept
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    for (int i = 0; i < WIDTH; i++) begin
      next_state.flags[i] = set[i] | (state.flags[i] & ~clear[i]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

endmodule

//--- testbench/pmic_mask_chk.sv
// pmic_mask_chk: port-level timing checks for the mask bank.
// assumes it is bound to pmic_interrupt_mask_bank.
`timescale 1ns/1ps
module pmic_mask_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire pmic_pkg::pmic_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // sources and views
  input wire logic otp_reset_event_suppress,
  input wire pmic_pkg::pmic_src_t src,
  input wire logic [7:0] system_irq_mask,
  input wire logic [7:0] reset_event_irq_mask,
  input wire logic [7:0] converter_irq_mask,
  input wire logic [pmic_pkg::PMIC_FLAG_WIDTH-1:0] event_flags
);
  import pmic_pkg::*;
  logic released;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // low up to the first edge after release, the edge that loads the otp bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      released <= 1'b0;
    end else begin
      released <= 1'b1;
    end
  end
  a_pg_masked_hold: assert property (system_irq_mask[7] |=> !$rose(event_flags[7]))
    else $error("pg flag set while masked");
  a_pg_flag_set: assert property (
    !system_irq_mask[7] && src.power_good_pin_state != $past(src.power_good_pin_state)
    |=> event_flags[7]) else $error("pg flag not set");
  a_thermal_flag_set: assert property (
    !system_irq_mask[2] && $rose(src.thermal_warning_state) |=> event_flags[2])
    else $error("thermal flag not set");
  a_conv1_pg_set: assert property (
    (!converter_irq_mask[7] && $rose(src.conv1_output_validity_state)) ||
    (!converter_irq_mask[6] && $fell(src.conv1_output_validity_state)) |=> event_flags[22])
    else $error("conv1 pg flag not set");
  a_conv_masked_hold: assert property (
    converter_irq_mask == 8'hdd && !reg_req.wr |=> $stable(event_flags[23:16]))
    else $error("conv flag moved while masked");
  a_conv_mask_write: assert property (
    reg_req.wr && reg_req.addr == PMIC_CONV_MASK_ADDR
    |=> converter_irq_mask == ($past(reg_req.wdata) & 8'hdd)) else $error("conv mask write");
  a_otp_mask_load: assert property (
    !released |=> reset_event_irq_mask[0] == $past(otp_reset_event_suppress))
    else $error("reset mask not from otp");
  a_flag_clear: assert property (
    reg_req.wr && reg_req.addr == PMIC_SYS_FLAG_ADDR && reg_req.wdata[2] && system_irq_mask[2]
    |=> !event_flags[2]) else $error("thermal flag not cleared");
  a_raw_pg_read: assert property (
    reg_req.rd && reg_req.addr == PMIC_TOP_STATE_ADDR
    |=> reg_rvalid && reg_rdata[7] == $past(src.power_good_pin_state)) else $error("raw pg");
endmodule

//--- testbench/pmic_host.sv
// pmic_host: register-port master in place of the serial engine.
// assumes its tasks are called from one process at a time.
`timescale 1ns/1ps
module pmic_host (
  // clock
  input wire logic clk,
  // register port
  output pmic_pkg::pmic_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  import pmic_pkg::*;
  initial reg_req = '0;
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // idle address and data are inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) reg_req = '{1'b1, 1'b0, a, d};
    @(negedge clk) reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) reg_req = '{1'b0, 1'b0, ~a, 8'hff};
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule

//--- testbench/pmic_interrupt_mask_bank_test.sv
// pmic_interrupt_mask_bank_test: self-checking bench for the mask bank.
// assumes the host model and the checker stand beside the design.
`timescale 1ns/1ps
module pmic_interrupt_mask_bank_test;
  import pmic_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic otp = 1'b0;
  pmic_src_t src = '0;
  pmic_reg_req_t reg_req;
  logic [7:0] rdata, sys_m, rst_m, conv_m;
  logic rvalid;
  logic [23:0] flags;
  int err_total = 0;
  int n_compared = 0;
  always #2 clk = ~clk;
  pmic_host HOST (.clk(clk), .reg_req(reg_req), .reg_rdata(rdata), .reg_rvalid(rvalid));
  pmic_interrupt_mask_bank DUT (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .otp_reset_event_suppress(otp), .src(src), .system_irq_mask(sys_m),
    .reset_event_irq_mask(rst_m), .converter_irq_mask(conv_m), .event_flags(flags));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    HOST.rd(a, v);
    n_compared++;
    if (v !== exp) begin
      $display("Error reg %h expected %h seen %h", a, exp, v);
      err_total++;
    end
  endtask
  // port views are compared at a falling edge, well clear of the edge that updates them
  task automatic pchk(input string what, input logic [23:0] exp, input logic [23:0] seen);
    n_compared++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask
  task automatic do_reset(input logic o);
    @(negedge clk) rst_n = 1'b0;
    otp = o;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // pulse sources last one cycle, level sources stay for the next hit
  task automatic hit(input pmic_src_t v, input logic [23:0] e);
    HOST.wr(PMIC_SYS_FLAG_ADDR, 8'hff);
    HOST.wr(PMIC_RST_FLAG_ADDR, 8'hff);
    HOST.wr(PMIC_CONV_FLAG_ADDR, 8'hff);
    @(negedge clk) src = v;
    @(negedge clk) src = pmic_src_t'(v & 9'h1cf);
    rchk(PMIC_TOP_STATE_ADDR, {v[8], 2'b00, v[7], 1'b0, v[6], 2'b00});
    rchk(PMIC_CONV_STATE_ADDR, {1'b0, v[1], 1'b0, v[0], 1'b0, v[3], 1'b0, v[2]});
    rchk(PMIC_SYS_FLAG_ADDR, e[7:0]);
    rchk(PMIC_RST_FLAG_ADDR, e[15:8]);
    rchk(PMIC_CONV_FLAG_ADDR, e[23:16]);
    pchk("event_flags", e, flags);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults();
    do_reset(1'b0);
    rchk(PMIC_SYS_MASK_ADDR, 8'h91);
    rchk(PMIC_RST_MASK_ADDR, 8'h00);
    rchk(PMIC_CONV_MASK_ADDR, 8'hdd);
    rchk(8'h30, 8'h00);
    pchk("system_irq_mask", 24'h000091, {16'h0000, sys_m});
    pchk("reset_event_irq_mask", 24'h000000, {16'h0000, rst_m});
    pchk("converter_irq_mask", 24'h0000dd, {16'h0000, conv_m});
    hit(9'h100, 24'h0);
    hit(9'h080, 24'h0);
    hit(9'h040, 24'h000004);
    hit(9'h020, 24'h0);
    hit(9'h010, 24'h000100);
    hit(9'h00f, 24'h0);
    hit(9'h000, 24'h0);
  endtask
  task automatic t_unmasked();
    HOST.wr(PMIC_CONV_MASK_ADDR, 8'hff);
    rchk(PMIC_CONV_MASK_ADDR, 8'hdd);
    HOST.wr(PMIC_RST_MASK_ADDR, 8'hfe);
    rchk(PMIC_RST_MASK_ADDR, 8'hfe);
    HOST.wr(PMIC_SYS_MASK_ADDR, 8'h00);
    HOST.wr(PMIC_CONV_MASK_ADDR, 8'h00);
    hit(9'h100, 24'h000080);
    hit(9'h000, 24'h000080);
    hit(9'h080, 24'h000010);
    hit(9'h000, 24'h000010);
    hit(9'h020, 24'h000001);
    hit(9'h010, 24'h000100);
    hit(9'h002, 24'h400000);
    hit(9'h000, 24'h400000);
    hit(9'h001, 24'h100000);
    hit(9'h008, 24'h040000);
    hit(9'h000, 24'h040000);
    hit(9'h004, 24'h010000);
    hit(9'h000, 24'h0);
  endtask
  task automatic t_split();
    HOST.wr(PMIC_SYS_MASK_ADDR, 8'hff);
    rchk(PMIC_SYS_MASK_ADDR, 8'hff);
    HOST.wr(PMIC_CONV_MASK_ADDR, 8'h88);
    rchk(PMIC_CONV_MASK_ADDR, 8'h88);
    hit(9'h00a, 24'h0);
    hit(9'h000, 24'h440000);
    HOST.wr(PMIC_CONV_MASK_ADDR, 8'h44);
    hit(9'h00a, 24'h440000);
    hit(9'h000, 24'h0);
  endtask
  task automatic t_otp();
    do_reset(1'b1);
    pchk("event_flags", 24'h000000, flags);
    pchk("reset_event_irq_mask", 24'h000001, {16'h0000, rst_m});
    rchk(PMIC_RST_MASK_ADDR, 8'h01);
    HOST.wr(PMIC_RST_MASK_ADDR, 8'h00);
    hit(9'h010, 24'h000100);
    do_reset(1'b1);
    rchk(PMIC_RST_MASK_ADDR, 8'h01);
    hit(9'h010, 24'h0);
  endtask
  initial begin
    t_defaults();
    t_unmasked();
    t_split();
    t_otp();
    end_of_test();
  end
  // the run needs well under 5000 cycles
  initial begin
    #40000;
    err_total++;
    end_of_test();
  end
endmodule
bind pmic_interrupt_mask_bank pmic_mask_chk CHK (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .otp_reset_event_suppress(otp_reset_event_suppress), .src(src),
  .system_irq_mask(system_irq_mask), .reset_event_irq_mask(reset_event_irq_mask),
  .converter_irq_mask(converter_irq_mask), .event_flags(event_flags));
